// *** src/can_node_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the CAN node control block.
// Assumes: APB byte addresses, one aligned 32-bit word per 8-bit register.
// Notes: Functional notes follow.
`ifndef CAN_NODE_DEFINES_SVH
`define CAN_NODE_DEFINES_SVH

`define OFF_IRQ_STATUS      8'h00
`define OFF_IRQ_ENABLE      8'h04
`define OFF_NODE_CTRL       8'h08
`define OFF_PRESCALER       8'h0C
`define OFF_SEG_TIMING      8'h10
`define OFF_PAGE_SELECT     8'h14
`define OFF_LAST_NAME_HI    8'h18
`define OFF_LAST_NAME_LO    8'h1C
`define OFF_TX_FAULT        8'h20
`define OFF_RX_FAULT        8'h24
`define OFF_MSG_NAME_HI     8'h28
`define OFF_MSG_NAME_LO     8'h2C
`define OFF_BUF_SELECT      8'h30

`define RST_IRQ_ENABLE      8'h00
`define RST_NODE_CTRL       8'h00
`define RST_PRESCALER       8'h00
`define RST_SEG_TIMING      8'h23
`define RST_PAGE_SELECT     8'h00

`define BIT_TX_ERR_FLAG     1
`define BIT_ERR_PENDING     0
`define BIT_SC_FLAG         3
`define BIT_OVR_FLAG        2
`define BIT_TX_OK_FLAG      4
`define BIT_EXTENDED_STATUS_CHANGE            6
`define BIT_RX_OK_IRQ_EN            5
`define BIT_TX_DONE_IRQ_EN            4
`define BIT_STATUS_CHANGE_IRQ_EN            3
`define BIT_OVERRUN_IRQ_EN            2
`define BIT_TX_FAULT_IRQ_EN            1
`define BIT_ETX             0
`define BIT_BUS_OFF_STATE            6
`define BIT_ERROR_PASSIVE_STATE            5
`define BIT_SELF_RECEIVE_EN            4
`define BIT_NO_RETRY            3
`define BIT_FAST_SYNC            2
`define BIT_WAKE_PULSE            1
`define BIT_RUN             0

`define SYNC_RECESSIVE_BITS 11
`define SYNC_SLOW_SEQS      128
`define TX_ERR_STEP         8
`define PASSIVE_LIMIT       127
`define BUS_OFF_LIMIT       256
`define RX_RELOAD_VALUE     120
`define RX_RELOAD_ABOVE     128
`define WAKE_PULSE_QUANTA   1
`define NUM_BUFFERS         3

`endif

// *** src/can_node_pkg.sv ***
// Purpose: Types shared by the CAN node control block.
// Assumes: Nothing beyond the defines header.
// Notes: Bus events arrive as one packed struct from the protocol engine.
package can_node_pkg;

    typedef enum logic [2:0] {
        PAGE_DIAG, PAGE_BUF1, PAGE_BUF2, PAGE_BUF3, PAGE_FILTER, PAGE_RSV
    } page_sel_t;

    typedef enum {
        NODE_STANDBY, NODE_SYNC, NODE_WAKE, NODE_RUN, NODE_STOPPING
    } node_state_t;

    typedef struct packed {
        logic        arb_won;
        logic        tx_ok;
        logic        tx_err;
        logic        rx_ok;
        logic        rx_err;
        logic        rx_err_heavy;
        logic        rx_overrun;
        logic        rx_own;
        logic        frame_hdr;
        logic [10:0] hdr_name;
        logic        hdr_remote;
        logic [3:0]  hdr_length;
        logic        busy;
        logic        rejoin;
    } bus_event_t;

    typedef struct packed {
        logic [5:0] quantum_prescale;
        logic [1:0] jump_width;
        logic [3:0] segment_one_len;
        logic [2:0] segment_two_len;
    } bit_timing_t;

endpackage

// *** src/can_node_control_status.sv ***
// Purpose: CAN node interrupt flags, control, bit timing, paging and fault confinement.
// Assumes: Bus events are one-cycle pulses synchronous to pclk; bit_tick pulses once per bit.
// Notes: APB slave with zero wait states; unmapped addresses read zero and flag pslverr.
`timescale 1ns/1ps
`include "can_node_defines.svh"

module can_node_control_status
    import can_node_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire bus_event_t  bus_evt,
    input  wire logic        bit_tick,
    input  wire logic        bus_rx_level,
    output logic             irq_request,
    output logic             rx_accept_own,
    output logic             retry_enable,
    output logic             early_tx_mode,
    output logic             node_running,
    output logic             wake_drive,
    output bit_timing_t      timing,
    output logic [7:0]       quantum_cycles,
    output logic [2:0]       jump_quanta,
    output logic [4:0]       bit_quanta,
    output page_sel_t        page_decode
);

    logic [4:0]  flag_reg;
    logic [7:0]  irq_enable_ctrl_reg;
    logic [4:0]  ctrl_reg;
    logic        run_status_reg;
    logic [7:0]  quantum_prescaler_reg;
    logic [6:0]  segment_timing_reg;
    logic [2:0]  page_select_reg;
    logic [10:0] previous_msg_name_reg;
    logic        previous_remote_req_reg;
    logic [3:0]  previous_length_code_reg;
    logic [8:0]  tx_fault_counter_reg;
    logic [7:0]  rx_fault_counter_reg;
    logic [1:0]  buf_sel_reg;
    logic [7:0]  msg_name_high_reg [`NUM_BUFFERS];
    logic [7:0]  msg_name_low_reg  [`NUM_BUFFERS];
    logic [3:0]  recessive_cnt_reg;
    logic [7:0]  seq_cnt_reg;
    logic [7:0]  wake_cnt_reg;
    logic        bus_off_state;
    logic        error_passive_state;
    logic        passive_prev_reg;
    logic        bus_off_state_prev_reg;
    node_state_t state_reg;
    node_state_t state_next;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        standby;
    logic        status_change;
    logic        tx_done_evt;
    logic [7:0]  rd_mux;
    logic [4:0]  flag_keep;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    function automatic page_sel_t page_of(input logic [2:0] code);
        case (code)
            3'h0:    return PAGE_DIAG;
            3'h1:    return PAGE_BUF1;
            3'h2:    return PAGE_BUF2;
            3'h3:    return PAGE_BUF3;
            3'h4:    return PAGE_FILTER;
            default: return PAGE_RSV;
        endcase
    endfunction

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !pwrite;
    assign pready  = 1'b1;
    assign addr_ok = paddr <= `OFF_BUF_SELECT && paddr[1:0] == 2'b00;
    assign pslverr = psel && penable && !addr_ok;
    assign standby = state_reg == NODE_STANDBY;

    // Node state bits follow the fault counters directly.
    assign bus_off_state       = tx_fault_counter_reg[8];
    assign error_passive_state = !bus_off_state &&
        (tx_fault_counter_reg > 9'(`PASSIVE_LIMIT) ||
         rx_fault_counter_reg > 8'(`PASSIVE_LIMIT));

    assign tx_done_evt = irq_enable_ctrl_reg[`BIT_ETX] ? bus_evt.arb_won
                                                        : bus_evt.tx_ok;
    assign status_change =
        (state_reg == NODE_RUN &&
         (error_passive_state != passive_prev_reg || bus_off_state != bus_off_state_prev_reg)) ||
        (standby && !bus_rx_level) ||
        (irq_enable_ctrl_reg[`BIT_EXTENDED_STATUS_CHANGE] && bus_evt.rx_err);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            passive_prev_reg <= 1'b0;
            bus_off_state_prev_reg    <= 1'b0;
        end else begin
            passive_prev_reg <= error_passive_state;
            bus_off_state_prev_reg    <= bus_off_state;
        end
    end

    // A zero written to a flag position clears it; every other flag is kept.
    assign flag_keep = (wr_en && hit(paddr, `OFF_IRQ_STATUS)) ? {pwdata[4:1], pwdata[7]}
                                                                : 5'h1F;

    // Flags: bit 0 rx ok, 1 tx error, 2 overrun, 3 status change, 4 tx done (arb won when ETX is set, else tx ok).
    // A set in the same cycle as a software clear wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 5'h00;
        end else begin
            flag_reg <= (flag_reg & flag_keep) | {tx_done_evt, status_change,
                        bus_evt.rx_overrun, bus_evt.tx_err, bus_evt.rx_ok};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= (flag_reg[0] && irq_enable_ctrl_reg[`BIT_RX_OK_IRQ_EN]) ||
                           (flag_reg[4] && irq_enable_ctrl_reg[`BIT_TX_DONE_IRQ_EN]) ||
                           (flag_reg[3] && irq_enable_ctrl_reg[`BIT_STATUS_CHANGE_IRQ_EN]) ||
                           (flag_reg[2] && irq_enable_ctrl_reg[`BIT_OVERRUN_IRQ_EN]) ||
                           (flag_reg[1] && irq_enable_ctrl_reg[`BIT_TX_FAULT_IRQ_EN]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_ctrl_reg <= `RST_IRQ_ENABLE;
            ctrl_reg            <= 5'(`RST_NODE_CTRL);
            page_select_reg     <= 3'(`RST_PAGE_SELECT);
            buf_sel_reg         <= 2'd0;
        end else if (wr_en) begin
            if (hit(paddr, `OFF_IRQ_ENABLE)) irq_enable_ctrl_reg <= {1'b0, pwdata[6:0]};
            if (hit(paddr, `OFF_NODE_CTRL))  ctrl_reg <= pwdata[4:0];
            if (hit(paddr, `OFF_PAGE_SELECT)) page_select_reg <= pwdata[2:0];
            if (hit(paddr, `OFF_BUF_SELECT)) buf_sel_reg <= pwdata[1:0];
        end
    end

    // Timing registers accept writes only in standby.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quantum_prescaler_reg <= `RST_PRESCALER;
            segment_timing_reg    <= 7'(`RST_SEG_TIMING);
        end else if (wr_en && standby) begin
            if (hit(paddr, `OFF_PRESCALER))  quantum_prescaler_reg <= pwdata[7:0];
            if (hit(paddr, `OFF_SEG_TIMING)) segment_timing_reg <= pwdata[6:0];
        end
    end

    assign timing = '{quantum_prescale: quantum_prescaler_reg[5:0],
                      jump_width:       quantum_prescaler_reg[7:6],
                      segment_one_len:  segment_timing_reg[3:0],
                      segment_two_len:  segment_timing_reg[6:4]};
    assign quantum_cycles = {2'b00, timing.quantum_prescale} + 8'd1;
    assign jump_quanta    = {1'b0, timing.jump_width} + 3'd1;
    assign bit_quanta     = {1'b0, timing.segment_one_len} +
                            {2'b00, timing.segment_two_len} + 5'd3;
    assign page_decode    = page_of(page_select_reg);
    assign rx_accept_own  = ctrl_reg[`BIT_SELF_RECEIVE_EN];
    assign retry_enable   = !ctrl_reg[`BIT_NO_RETRY];
    assign early_tx_mode  = irq_enable_ctrl_reg[`BIT_ETX];
    assign node_running   = state_reg == NODE_RUN || state_reg == NODE_STOPPING;

    // Run sequencing: synchronise on recessive runs, optional wake pulse, drain on stop.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NODE_STANDBY:  if (ctrl_reg[`BIT_RUN]) state_next = NODE_SYNC;
            NODE_SYNC: begin
                if (!ctrl_reg[`BIT_RUN]) begin
                    state_next = NODE_STANDBY;
                end else if (bit_tick && bus_rx_level &&
                             recessive_cnt_reg == 4'(`SYNC_RECESSIVE_BITS - 1) &&
                             (ctrl_reg[`BIT_FAST_SYNC] ||
                              seq_cnt_reg == 8'(`SYNC_SLOW_SEQS - 1))) begin
                    state_next = ctrl_reg[`BIT_WAKE_PULSE] ? NODE_WAKE : NODE_RUN;
                end
            end
            NODE_WAKE:     if (wake_cnt_reg == 8'd0) state_next = NODE_RUN;
            NODE_RUN:      if (!ctrl_reg[`BIT_RUN]) state_next = NODE_STOPPING;
            NODE_STOPPING: if (!bus_evt.busy) state_next = NODE_STANDBY;
            default:       state_next = NODE_STANDBY;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= NODE_STANDBY;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recessive_cnt_reg <= 4'd0;
            seq_cnt_reg       <= 8'd0;
        end else if (state_reg != NODE_SYNC) begin
            recessive_cnt_reg <= 4'd0;
            seq_cnt_reg       <= 8'd0;
        end else if (bit_tick) begin
            if (!bus_rx_level) begin
                recessive_cnt_reg <= 4'd0;
            end else if (recessive_cnt_reg == 4'(`SYNC_RECESSIVE_BITS - 1)) begin
                recessive_cnt_reg <= 4'd0;
                seq_cnt_reg       <= seq_cnt_reg + 8'd1;
            end else begin
                recessive_cnt_reg <= recessive_cnt_reg + 4'd1;
            end
        end
    end

    // Wake pulse lasts one quantum, counted in pclk cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt_reg <= 8'd0;
        end else if (state_reg != NODE_WAKE) begin
            wake_cnt_reg <= quantum_cycles * 8'(`WAKE_PULSE_QUANTA) - 8'd1;
        end else if (wake_cnt_reg != 8'd0) begin
            wake_cnt_reg <= wake_cnt_reg - 8'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_drive <= 1'b0;
        end else begin
            wake_drive <= state_next == NODE_WAKE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_status_reg <= 1'b0;
        end else begin
            run_status_reg <= ctrl_reg[`BIT_RUN] || state_next == NODE_STOPPING;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_fault_counter_reg <= 9'd0;
        end else if (bus_evt.rejoin && bus_off_state) begin
            tx_fault_counter_reg <= 9'd0;
        end else if (bus_evt.tx_err && !bus_off_state) begin
            tx_fault_counter_reg <= (tx_fault_counter_reg > 9'(`BUS_OFF_LIMIT - `TX_ERR_STEP))
                ? 9'(`BUS_OFF_LIMIT) : tx_fault_counter_reg + 9'(`TX_ERR_STEP);
        end else if (bus_evt.tx_ok && tx_fault_counter_reg != 9'd0 && !bus_off_state) begin
            tx_fault_counter_reg <= tx_fault_counter_reg - 9'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_fault_counter_reg <= 8'd0;
        end else if (bus_evt.rx_err) begin
            rx_fault_counter_reg <= bus_evt.rx_err_heavy
                ? ((rx_fault_counter_reg > 8'd247) ? 8'hFF : rx_fault_counter_reg + 8'd8)
                : ((rx_fault_counter_reg == 8'hFF) ? 8'hFF : rx_fault_counter_reg + 8'd1);
        end else if (bus_evt.rx_ok) begin
            if (rx_fault_counter_reg > 8'(`RX_RELOAD_ABOVE)) begin
                rx_fault_counter_reg <= 8'(`RX_RELOAD_VALUE);
            end else if (rx_fault_counter_reg != 8'd0) begin
                rx_fault_counter_reg <= rx_fault_counter_reg - 8'd1;
            end
        end
    end

    // Last identifier capture; software may also overwrite it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            previous_msg_name_reg    <= 11'd0;
            previous_remote_req_reg  <= 1'b0;
            previous_length_code_reg <= 4'd0;
        end else if (bus_evt.frame_hdr && (!bus_evt.rx_own || rx_accept_own)) begin
            previous_msg_name_reg    <= bus_evt.hdr_name;
            previous_remote_req_reg  <= bus_evt.hdr_remote;
            previous_length_code_reg <= bus_evt.hdr_length;
        end else if (wr_en && hit(paddr, `OFF_LAST_NAME_HI)) begin
            previous_msg_name_reg[10:3] <= pwdata[7:0];
        end else if (wr_en && hit(paddr, `OFF_LAST_NAME_LO)) begin
            previous_msg_name_reg[2:0]  <= pwdata[7:5];
            previous_remote_req_reg     <= pwdata[4];
            previous_length_code_reg    <= pwdata[3:0];
        end
    end

    generate
        for (genvar b = 0; b < `NUM_BUFFERS; b++) begin : g_name
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    msg_name_high_reg[b] <= 8'h00;
                    msg_name_low_reg[b]  <= 8'h00;
                end else if (wr_en && buf_sel_reg == 2'(b)) begin
                    if (hit(paddr, `OFF_MSG_NAME_HI)) begin
                        msg_name_high_reg[b] <= pwdata[7:0];
                    end
                    if (hit(paddr, `OFF_MSG_NAME_LO)) begin
                        msg_name_low_reg[b] <= {pwdata[7:4],
                            (pwdata[3:0] > 4'd8) ? 4'd8 : pwdata[3:0]};
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        rd_mux = 8'h00;
        case (paddr)
            `OFF_IRQ_STATUS:   rd_mux = {flag_reg[0], 2'b00, flag_reg[4:1],
                                         |flag_reg[3:1]};
            `OFF_IRQ_ENABLE:   rd_mux = irq_enable_ctrl_reg;
            `OFF_NODE_CTRL:    rd_mux = {1'b0, bus_off_state, error_passive_state,
                                         ctrl_reg[4:1], run_status_reg};
            `OFF_PRESCALER:    rd_mux = quantum_prescaler_reg;
            `OFF_SEG_TIMING:   rd_mux = {1'b0, segment_timing_reg};
            `OFF_PAGE_SELECT:  rd_mux = {5'b00000, page_select_reg};
            `OFF_LAST_NAME_HI: rd_mux = previous_msg_name_reg[10:3];
            `OFF_LAST_NAME_LO: rd_mux = {previous_msg_name_reg[2:0], previous_remote_req_reg,
                                         previous_length_code_reg};
            `OFF_TX_FAULT:     rd_mux = tx_fault_counter_reg[7:0];
            `OFF_RX_FAULT:     rd_mux = rx_fault_counter_reg;
            `OFF_MSG_NAME_HI:  rd_mux = (buf_sel_reg < 2'd3) ? msg_name_high_reg[buf_sel_reg]
                                                            : 8'h00;
            `OFF_MSG_NAME_LO:  rd_mux = (buf_sel_reg < 2'd3) ? msg_name_low_reg[buf_sel_reg]
                                                            : 8'h00;
            `OFF_BUF_SELECT:   rd_mux = {6'b000000, buf_sel_reg};
            default:           rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            prdata <= {24'h000000, rd_mux};
        end
    end

endmodule // can_node_control_status

// *** sim/can_bus_peer.sv ***
// Purpose: Far-side bus model that feeds events, bit ticks and bus level.
// Assumes: Events are one-cycle pulses launched just after a clock edge.
// Notes: The idle bus is recessive, so the level line rests high.
`timescale 1ns/1ps
module can_bus_peer
    import can_node_pkg::*;
(
    input  wire logic pclk,
    output bus_event_t bus_evt,
    output logic       bit_tick,
    output logic       bus_rx_level
);
    logic [1:0] div_reg = 2'h0;
    initial bus_evt = '0;
    assign bus_rx_level = 1'b1;
    assign bit_tick     = (div_reg == 2'h3);
    always @(posedge pclk) begin
        div_reg <= div_reg + 2'h1;
    end
    task automatic fire(input bus_event_t e);
        @(posedge pclk);
        bus_evt <= e;
        @(posedge pclk);
        bus_evt <= '0;
    endtask
endmodule // can_bus_peer

// *** sim/can_node_control_status_chk.sv ***
// Purpose: Port-level assertions of the CAN node control block.
// Assumes: Zero-wait APB slave; timing outputs follow the raw fields.
// Notes: Bound into every instance of the block.
`timescale 1ns/1ps
module can_node_control_status_chk
    import can_node_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        node_running,
    input wire logic        wake_drive,
    input wire logic [7:0]  paddr,
    input wire logic [7:0]  quantum_cycles,
    input wire logic [31:0] prdata,
    input wire bit_timing_t timing,
    input wire logic [2:0]  jump_quanta,
    input wire logic [4:0]  bit_quanta
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_always: assert property (psel |-> pready) else $error("pready low");
    chk_quantum_span: assert property (
        quantum_cycles == {2'b00, timing.quantum_prescale} + 8'h01) else $error("quantum");
    chk_jump_span: assert property (
        jump_quanta == {1'b0, timing.jump_width} + 3'h1) else $error("jump width");
    chk_bit_span: assert property (bit_quanta == {1'b0, timing.segment_one_len}
        + {2'b00, timing.segment_two_len} + 5'h03) else $error("bit quanta");
    chk_timing_frozen: assert property (
        node_running |=> $stable(timing)) else $error("timing changed in run");
    chk_read_hold: assert property (
        !(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
    chk_wake_standby: assert property (
        wake_drive |-> !node_running) else $error("wake pulse while running");
    chk_addr_refuse: assert property (psel && penable |->
        pslverr == (paddr > 8'h30 || paddr[1:0] != 2'b00)) else $error("pslverr wrong");
    cover property ($rose(node_running));
    cover property (psel && penable && pslverr);
    cover property (node_running && psel && penable && pwrite && paddr == 8'h0C);
endmodule // can_node_control_status_chk
bind can_node_control_status can_node_control_status_chk u_can_node_control_status_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .node_running(node_running),
    .wake_drive(wake_drive), .paddr(paddr), .quantum_cycles(quantum_cycles),
    .prdata(prdata), .timing(timing), .jump_quanta(jump_quanta), .bit_quanta(bit_quanta));

// *** sim/tb_can_node_control_status.sv ***
// Purpose: Self-checking bench of the CAN node control block.
// Assumes: Zero-wait APB; events come from the bus peer model.
// Notes: Reset is held for 16 cycles.
`timescale 1ns/1ps
module tb_can_node_control_status
    import can_node_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, q, quantum_cycles;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq_request, node_running, bit_tick, bus_rx_level;
    logic rx_accept_own, retry_enable, early_tx_mode;
    logic [2:0] jump_quanta;
    logic [4:0] bit_quanta;
    bus_event_t bus_evt;
    bit_timing_t timing;
    page_sel_t page_decode;
    int errors = 0, samples_checked = 0;
    always #25 pclk = ~pclk;
    can_bus_peer u_can_bus_peer (.pclk(pclk), .bus_evt(bus_evt), .bit_tick(bit_tick),
        .bus_rx_level(bus_rx_level));
    can_node_control_status u_can_node_control_status (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_evt(bus_evt),
        .bit_tick(bit_tick), .bus_rx_level(bus_rx_level), .irq_request(irq_request),
        .rx_accept_own(rx_accept_own), .retry_enable(retry_enable),
        .early_tx_mode(early_tx_mode), .node_running(node_running),
        .wake_drive(), .timing(timing), .quantum_cycles(quantum_cycles),
        .jump_quanta(jump_quanta), .bit_quanta(bit_quanta), .page_decode(page_decode));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            wrap_up();
        end else begin
            q = prdata[7:0];
            {psel, penable} <= 2'b00;
        end
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        cmp(nm, {24'h000000, exp}, {24'h000000, q});
    endtask
    task automatic t_reset();
        logic [7:0] ofs [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24};
        for (int i = 0; i < 7; i++) rd("reset value", ofs[i], (ofs[i] == 8'h10) ? 8'h23 : 8'h00);
        rd("unmapped read", 8'h34, 8'h00);
        $display("test reset values done");
    endtask
    task automatic t_flags();
        bus_event_t e;
        apb(1'b1, 8'h04, 8'h02);
        e = '0; e.tx_err = 1'b1; u_can_bus_peer.fire(e);
        rd("flags after tx error", 8'h00, 8'h03);
        cmp("irq enabled", 32'h1, {31'h0, irq_request});
        e = '0; e.tx_ok = 1'b1; u_can_bus_peer.fire(e);
        apb(1'b1, 8'h00, 8'hFD);
        rd("flags after mask clear", 8'h00, 8'h10);
        cmp("irq gated", 32'h0, {31'h0, irq_request});
        rd("tx fault count", 8'h20, 8'h07);
        apb(1'b1, 8'h04, 8'h01);
        apb(1'b1, 8'h00, 8'h00);
        e = '0; e.arb_won = 1'b1; u_can_bus_peer.fire(e);
        rd("early tx flag", 8'h00, 8'h10);
        e = '0; e.frame_hdr = 1'b1; e.hdr_name = 11'h5A3; e.hdr_remote = 1'b1;
        e.hdr_length = 4'h6; u_can_bus_peer.fire(e);
        rd("last name high", 8'h18, 8'hB4);
        rd("last name low", 8'h1C, 8'h76);
        e = '0; e.frame_hdr = 1'b1; e.rx_own = 1'b1; e.hdr_name = 11'h123;
        u_can_bus_peer.fire(e);
        rd("own frame dropped", 8'h18, 8'hB4);
        apb(1'b1, 8'h30, 8'h01);
        apb(1'b1, 8'h2C, 8'hAF);
        rd("length code capped", 8'h2C, 8'hA8);
        apb(1'b1, 8'h28, 8'h5A);
        rd("buffer name high", 8'h28, 8'h5A);
        apb(1'b1, 8'h30, 8'h00);
        rd("other buffer kept", 8'h28, 8'h00);
        $display("test flags done");
    endtask
    task automatic t_run();
        int n;
        for (int v = 0; v < 8; v++) begin
            apb(1'b1, 8'h14, 8'(v));
            @(negedge pclk);
            cmp("page decode", (v < 5) ? v : 32'(PAGE_RSV), 32'(page_decode));
        end
        apb(1'b1, 8'h0C, 8'hC5);
        @(negedge pclk);
        cmp("quantum cycles", 32'd6, {24'h0, quantum_cycles});
        cmp("jump quanta", 32'd4, {29'h0, jump_quanta});
        cmp("bit quanta", 32'd8, {27'h0, bit_quanta});
        apb(1'b1, 8'h08, 8'h05);
        n = 0;
        while (node_running !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
        cmp("fast sync wait", 32'h1, {31'h0, n >= 36 && n < 60});
        if (n >= 200) wrap_up();
        apb(1'b1, 8'h0C, 8'h00);
        rd("prescaler locked", 8'h0C, 8'hC5);
        apb(1'b1, 8'h08, 8'h04);
        repeat (2) @(posedge pclk);
        rd("run cleared when idle", 8'h08, 8'h04);
        apb(1'b1, 8'h08, 8'h18);
        @(negedge pclk);
        cmp("self receive", 32'h1, {31'h0, rx_accept_own});
        cmp("retry off", 32'h0, {31'h0, retry_enable});
        cmp("early tx mode", 32'h1, {31'h0, early_tx_mode});
        $display("test timing and run done");
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_flags();
        t_run();
        wrap_up();
    end
endmodule // tb_can_node_control_status
